// >>> rtl/lmac_cfg.svh
// Constants for the lane marker and alignment configuration bank.
// Assumes inclusion by bare name from files under rtl/.
`ifndef LMAC_CFG_SVH
`define LMAC_CFG_SVH

// Register offsets on the plain register port
`define LMAC_ADDR_W        8
`define LMAC_DATA_W        16
`define LMAC_OFS_HAM       8'h17
`define LMAC_OFS_RMD       8'h18
`define LMAC_OFS_FSC       8'h19
`define LMAC_OFS_LSS       8'h1b
`define LMAC_OFS_SCOPE     8'h30
`define LMAC_OFS_LINK      8'h31
`define LMAC_OFS_STAT      8'h32

// Reset values
`define LMAC_RST_HAM       16'h02bc
`define LMAC_RST_RMD       16'h0cc8
`define LMAC_RST_FSC       16'h02bc
`define LMAC_RST_LSS       16'h3020
`define LMAC_RST_SCOPE     16'h000f
`define LMAC_RST_LINK      16'h0000

// Field positions
`define LMAC_MSEL_HI       14
`define LMAC_MSEL_LO       12
`define LMAC_MEN_BIT       11
`define LMAC_DEPTH_HI      15
`define LMAC_DEPTH_LO      13
`define LMAC_WMK_HI        12
`define LMAC_WMK_LO        11
`define LMAC_SCEN_BIT      10
`define LMAC_SCODE_HI      9
`define LMAC_SCODE_LO      0
`define LMAC_MASK_HI       3
`define LMAC_MASK_LO       0
`define LMAC_SLANE_HI      5
`define LMAC_SLANE_LO      4
`define LMAC_RLANE_HI      7
`define LMAC_RLANE_LO      6
`define LMAC_IL_BIT        0
`define LMAC_LSM_BIT       1
`define LMAC_LOS_BIT       2

// Marker message constant check word and repeat interval
`define LMAC_MARKER_CRC    32'hfe0000fe
`define LMAC_MARKER_PERIOD 16

`endif

// >>> rtl/lmac_lane_reg.sv
// One lane's source select register with a lane-dependent reset value.
// Assumes the caller gates the write enable with the lane scope mask.
`timescale 1ns/1ps
`default_nettype none
`include "lmac_cfg.svh"

module lmac_lane_reg
	import lmac_pkg::*;
#(
	parameter logic [2:0] LANE = 3'h0
) (
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	input  wire logic                      wr_en,
	input  wire logic [`LMAC_DATA_W-1:0]   wdata,
	output lmac_lane_cfg_t                 q_r
);

	// Lane number lands in both lane fields of the base reset word
	localparam logic [15:0] RST = `LMAC_RST_LSS | {5'h00, LANE, 5'h00, LANE};

	// Word storage
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			q_r <= RST;                        // [RULE16]
		end else if (wr_en) begin
			q_r <= wdata;                      // [RULE15]
		end
	end

endmodule // lmac_lane_reg
`default_nettype wire

// >>> rtl/lmac_marker_gen.sv
// Lane marker message generator for the low-speed transmit side.
// Assumes the enable is a registered level on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "lmac_cfg.svh"

module lmac_marker_gen
	import lmac_pkg::*;
#(
	parameter int PERIOD = `LMAC_MARKER_PERIOD
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        gen_en,
	input  wire logic [2:0]  lane_sel,
	output lmac_marker_msg_t msg_r,
	output logic             msg_valid_r
);

	localparam logic [7:0] LAST = 8'(PERIOD - 1);

	logic [7:0]  tick_r;
	logic [28:0] seq_r;

	// Interval counter; restarts so the first marker follows the enable at once
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !gen_en) begin
			tick_r <= 8'h00;
		end else if (tick_r == LAST) begin
			tick_r <= 8'h00;
		end else begin
			tick_r <= tick_r + 8'h01;
		end
	end

	// Message issue with fixed check word
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			msg_r       <= '0;
			msg_valid_r <= 1'b0;
			seq_r       <= 29'h0;
		end else begin
			msg_valid_r <= gen_en && (tick_r == 8'h00);
			if (gen_en && (tick_r == 8'h00)) begin
				msg_r.lane <= lane_sel;
				msg_r.seq  <= seq_r;
				msg_r.crc  <= `LMAC_MARKER_CRC;    // [RULE3]
				seq_r      <= seq_r + 29'h1;
			end
		end
	end

endmodule // lmac_marker_gen
`default_nettype wire

// >>> rtl/lmac_pkg.sv
// Types shared by the lane marker and alignment configuration bank.
// Assumes lmac_cfg.svh holds all numeric constants.
package lmac_pkg;

	// One lane's source and rate word, laid out as the register stores it
	typedef struct packed {
		logic [1:0] rx_div_rate;
		logic       rx_ctc_en;
		logic [1:0] rx_src_sel;
		logic [2:0] rx_src_lane;
		logic [1:0] tx_div_rate;
		logic       tx_ctc_en;
		logic [1:0] tx_src_sel;
		logic [2:0] tx_src_lane;
	} lmac_lane_cfg_t;

	// Generated lane marker message
	typedef struct packed {
		logic [2:0]  lane;
		logic [28:0] seq;
		logic [31:0] crc;
	} lmac_marker_msg_t;

	typedef enum logic [1:0] {
		LMAC_SRC_LS_SAME = 2'h0,
		LMAC_SRC_LS_ALT  = 2'h1,
		LMAC_SRC_HS_SAME = 2'h2,
		LMAC_SRC_HS_ALT  = 2'h3
	} lmac_rx_src_t;

endpackage

// >>> rtl/lmac_top.sv
// Lane marker, transmit FIFO and lane source configuration bank.
// Assumes a same-clock register master and same-clock lane symbol inputs.
//
// Function
// RULE1: Transmit marker select, 3 bits at 14:12 of alignment control, resets zero.
// RULE2: Generation enable bit 11 makes markers in the chosen transmit lane; the code decodes only select bits 13:12 for the lane output.
// RULE3: Every generated marker message carries check word FE0000FE.
// RULE4: Markers also generate when both low-speed marker and loss enables are one.
// RULE5: Receive marker select, 3 bits at 14:12 of marker control, resets zero.
// RULE6: Detect enable bit 11, reset one, acts only with bitwise interleaving.
// RULE7: Transmit FIFO depth select at bits 15:13, resets zero.
// RULE8: Transmit FIFO watermark select at bits 12:11, resets zero.
// RULE9: Sync code enable bit 10 swaps in the programmed sync code.
// RULE10: Sync code is ten bits at 9:0, resetting to 2BC.
// RULE11: The lane using the sync code comes from the lane control register.
// RULE12: Receive divided rate at bits 15:14 for chosen lanes, resets zero.
// RULE13: Receive tolerance compensation enable at bit 13, resets one.
// RULE14: Source select 12:11 picks same/other channel, low/high speed input.
// RULE15: Per-lane field writes touch only lanes flagged in the enable mask.
// RULE16: Lane source register resets to 3020, 3121, 3222, 3323 per lane.
// RULE17: Bits 10:8 pick which lane of the chosen source feeds the output; the code uses only bits 9:8.
// RULE18: Software rewrites reserved fields with their reset values.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lmac_cfg.svh"

module lmac_top
	import lmac_pkg::*;
#(
	parameter int LANES  = 4,
	parameter int SYM_W  = 10,
	parameter int PERIOD = `LMAC_MARKER_PERIOD
) (
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	// Register port
	input  wire logic [`LMAC_ADDR_W-1:0]  reg_addr,
	input  wire logic [`LMAC_DATA_W-1:0]  reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [`LMAC_DATA_W-1:0]       reg_rdata,
	// Lane symbol sources for the receive output
	input  wire logic [LANES*SYM_W-1:0]   ls_same_in,
	input  wire logic [LANES*SYM_W-1:0]   ls_alt_in,
	input  wire logic [LANES*SYM_W-1:0]   hs_same_in,
	input  wire logic [LANES*SYM_W-1:0]   hs_alt_in,
	output logic [LANES*SYM_W-1:0]        rx_out,
	// Transmit marker controls
	output logic [2:0]                    tx_marker_select,
	output logic [LANES-1:0]              tx_marker_lane,
	output lmac_marker_msg_t              marker_msg,
	output logic                          marker_msg_valid,
	// Receive marker controls
	output logic [2:0]                    rx_marker_select,
	output logic                          rx_marker_detect_en,
	// Transmit FIFO and channel sync controls
	output logic [2:0]                    tx_fifo_depth_select,
	output logic [1:0]                    tx_fifo_watermark_select,
	output logic [LANES-1:0]              sync_code_override_enable,
	output logic [9:0]                    sync_code_value,
	// Per-lane source and rate settings
	output lmac_lane_cfg_t [LANES-1:0]    lane_cfg
);

	////////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [15:0]             ham_r;       // hs_alignment_marker_control
	logic [15:0]             rmd_r;       // rx_marker_detect_control
	logic [15:0]             fsc_r;       // ls_tx_fifo_and_sync_code
	logic [15:0]             scope_r;     // serdes_lane_control
	logic [15:0]             link_r;      // link mode bits
	logic [15:0]             rdata_r;
	logic [15:0]             rdata_nxt;
	logic                    wr_ham;
	logic                    wr_rmd;
	logic                    wr_fsc;
	logic                    wr_lss;
	logic                    wr_scope;
	logic                    wr_link;
	logic [LANES-1:0]        lane_mask;
	logic                    gen_en;
	logic                    gen_en_r;
	logic                    detect_en_r;
	logic [LANES-1:0]        tx_lane_r;
	logic [LANES-1:0]        sync_ovr_r;
	logic [15:0]             status;
	lmac_lane_cfg_t          rd_lane;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	// Write strobes per register
	always_comb begin
		wr_ham   = 1'b0;
		wr_rmd   = 1'b0;
		wr_fsc   = 1'b0;
		wr_lss   = 1'b0;
		wr_scope = 1'b0;
		wr_link  = 1'b0;
		if (!reg_wr) begin
			wr_ham = 1'b0;
		end else if (reg_addr == `LMAC_OFS_HAM) begin
			wr_ham = 1'b1;
		end else if (reg_addr == `LMAC_OFS_RMD) begin
			wr_rmd = 1'b1;
		end else if (reg_addr == `LMAC_OFS_FSC) begin
			wr_fsc = 1'b1;
		end else if (reg_addr == `LMAC_OFS_LSS) begin
			wr_lss = 1'b1;
		end else if (reg_addr == `LMAC_OFS_SCOPE) begin
			wr_scope = 1'b1;
		end else if (reg_addr == `LMAC_OFS_LINK) begin
			wr_link = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared registers

	// Transmit marker control; reserved bits keep whatever software writes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ham_r <= `LMAC_RST_HAM;            // [RULE1] [RULE2]
		end else if (wr_ham) begin
			ham_r <= reg_wdata;
		end
	end

	// Receive marker control
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rmd_r <= `LMAC_RST_RMD;            // [RULE5] [RULE6]
		end else if (wr_rmd) begin
			rmd_r <= reg_wdata;
		end
	end

	// Transmit FIFO and sync code
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			fsc_r <= `LMAC_RST_FSC;            // [RULE7] [RULE8] [RULE9] [RULE10]
		end else if (wr_fsc) begin
			fsc_r <= reg_wdata;
		end
	end

	// Lane scope: write mask, sync code lane, readback lane
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			scope_r <= `LMAC_RST_SCOPE;
		end else if (wr_scope) begin
			scope_r <= reg_wdata;
		end
	end

	// Link mode bits
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			link_r <= `LMAC_RST_LINK;
		end else if (wr_link) begin
			link_r <= reg_wdata;
		end
	end

	assign lane_mask = scope_r[`LMAC_MASK_HI:`LMAC_MASK_LO];

	////////////////////////////////////////////////////////////////////////////////
	// Per-lane source registers

	// One register per lane; a single write lands in every flagged lane at once.
	// Receive rate, compensation and source fields all live in this one word;
	// lanes left out of the mask keep their settings, so software can stage
	// one lane at a time without a read-modify-write of the others.
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		lmac_lane_reg #(
			.LANE (3'(i))
		) u_lane_reg (
			.sys_clk (sys_clk),
			.reset_n (reset_n),
			.wr_en   (wr_lss && lane_mask[i]),   // [RULE15]
			.wdata   (reg_wdata),
			.q_r     (lane_cfg[i])           // [RULE12] [RULE13]
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive output source mux

	// Source and lane choice per output lane, registered for clean timing
	for (genvar i = 0; i < LANES; i++) begin : g_rxmux
		logic [1:0] pick;
		logic [SYM_W-1:0] sym;

		assign pick = lane_cfg[i].rx_src_lane[1:0];   // [RULE17]

		always_comb begin
			sym = '0;
			case (lmac_rx_src_t'(lane_cfg[i].rx_src_sel))   // [RULE14]
				LMAC_SRC_LS_SAME: sym = ls_same_in[pick*SYM_W +: SYM_W];
				LMAC_SRC_LS_ALT:  sym = ls_alt_in[pick*SYM_W +: SYM_W];
				LMAC_SRC_HS_SAME: sym = hs_same_in[pick*SYM_W +: SYM_W];
				LMAC_SRC_HS_ALT:  sym = hs_alt_in[pick*SYM_W +: SYM_W];
				default:          sym = '0;
			endcase
		end

		always_ff @(posedge sys_clk) begin
			if (!reset_n) begin
				rx_out[i*SYM_W +: SYM_W] <= '0;
			end else begin
				rx_out[i*SYM_W +: SYM_W] <= sym;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit marker generation

	// Either the direct enable or the low-speed pair starts marker generation
	assign gen_en = ham_r[`LMAC_MEN_BIT]                            // [RULE2]
		|| (link_r[`LMAC_LSM_BIT] && link_r[`LMAC_LOS_BIT]);        // [RULE4]

	// Registered enable and lane decode; low two select bits name the lane
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			gen_en_r  <= 1'b0;
			tx_lane_r <= '0;
		end else begin
			gen_en_r  <= gen_en;
			tx_lane_r <= '0;
			if (gen_en) begin
				tx_lane_r[ham_r[`LMAC_MSEL_LO +: 2]] <= 1'b1;   // [RULE1] [RULE2]
			end
		end
	end

	lmac_marker_gen #(
		.PERIOD (PERIOD)
	) u_marker_gen (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.gen_en      (gen_en_r),
		.lane_sel    (ham_r[`LMAC_MSEL_HI:`LMAC_MSEL_LO]),
		.msg_r       (marker_msg),
		.msg_valid_r (marker_msg_valid)
	);

	assign tx_marker_select = ham_r[`LMAC_MSEL_HI:`LMAC_MSEL_LO];   // [RULE1]
	assign tx_marker_lane   = tx_lane_r;

	////////////////////////////////////////////////////////////////////////////////
	// Receive marker detection

	// Detection is gated off unless bitwise interleaving is in use.
	// Registered so the detector sees one clean level, at one cycle of lag.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			detect_en_r <= 1'b0;
		end else begin
			detect_en_r <= rmd_r[`LMAC_MEN_BIT] && link_r[`LMAC_IL_BIT];   // [RULE6]
		end
	end

	assign rx_marker_select    = rmd_r[`LMAC_MSEL_HI:`LMAC_MSEL_LO];   // [RULE5]
	assign rx_marker_detect_en = detect_en_r;

	////////////////////////////////////////////////////////////////////////////////
	// Transmit FIFO and channel sync code

	assign tx_fifo_depth_select     = fsc_r[`LMAC_DEPTH_HI:`LMAC_DEPTH_LO];  // [RULE7]
	assign tx_fifo_watermark_select = fsc_r[`LMAC_WMK_HI:`LMAC_WMK_LO];      // [RULE8]
	assign sync_code_value          = fsc_r[`LMAC_SCODE_HI:`LMAC_SCODE_LO];  // [RULE10]

	// Only the lane named in the scope register takes the programmed code
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sync_ovr_r <= '0;
		end else begin
			sync_ovr_r <= '0;
			if (fsc_r[`LMAC_SCEN_BIT]) begin                             // [RULE9]
				sync_ovr_r[scope_r[`LMAC_SLANE_HI:`LMAC_SLANE_LO]] <= 1'b1;  // [RULE11]
			end
		end
	end

	assign sync_code_override_enable = sync_ovr_r;

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	// Per-lane word seen at its offset is the one picked by the readback field
	assign rd_lane = lane_cfg[scope_r[`LMAC_RLANE_HI:`LMAC_RLANE_LO]];

	// Status shows live block state, not stored software values.
	// Read-only: a write to its offset matches no decode branch and is lost.
	// Limitation: the sequence byte wraps, so it only shows that markers move.
	assign status = {
		marker_msg.seq[7:0],
		3'h0,
		|sync_ovr_r,
		|tx_lane_r,
		marker_msg_valid,
		detect_en_r,
		gen_en_r
	};

	// Unmapped reads answer zero
	always_comb begin
		rdata_nxt = 16'h0000;
		if (!reg_rd) begin
			rdata_nxt = 16'h0000;
		end else if (reg_addr == `LMAC_OFS_HAM) begin
			rdata_nxt = ham_r;
		end else if (reg_addr == `LMAC_OFS_RMD) begin
			rdata_nxt = rmd_r;
		end else if (reg_addr == `LMAC_OFS_FSC) begin
			rdata_nxt = fsc_r;
		end else if (reg_addr == `LMAC_OFS_LSS) begin
			rdata_nxt = rd_lane;
		end else if (reg_addr == `LMAC_OFS_SCOPE) begin
			rdata_nxt = scope_r;
		end else if (reg_addr == `LMAC_OFS_LINK) begin
			rdata_nxt = link_r;
		end else if (reg_addr == `LMAC_OFS_STAT) begin
			rdata_nxt = status;
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

endmodule // lmac_top
`default_nettype wire

// >>> test/lmac_top_props.sv
// Concurrent checks on the ports of the lane marker configuration bank.
// Assumes one clock and the synchronous active-low reset of the top module.
`timescale 1ns/1ps
`default_nettype none
`include "lmac_cfg.svh"

module lmac_top_props
	import lmac_pkg::*;
#(
	parameter int LANES  = 4,
	parameter int PERIOD = `LMAC_MARKER_PERIOD
) (
	input wire logic                      sys_clk,
	input wire logic                      reset_n,
	input wire logic [`LMAC_ADDR_W-1:0]   reg_addr,
	input wire logic [`LMAC_DATA_W-1:0]   reg_wdata,
	input wire logic                      reg_wr,
	input wire logic                      reg_rd,
	input wire logic [`LMAC_DATA_W-1:0]   reg_rdata,
	input wire logic [2:0]                tx_marker_select,
	input wire logic [LANES-1:0]          tx_marker_lane,
	input wire lmac_marker_msg_t          marker_msg,
	input wire logic                      marker_msg_valid,
	input wire logic [2:0]                rx_marker_select,
	input wire logic                      rx_marker_detect_en,
	input wire logic [2:0]                tx_fifo_depth_select,
	input wire logic [1:0]                tx_fifo_watermark_select,
	input wire logic [LANES-1:0]          sync_code_override_enable,
	input wire logic [9:0]                sync_code_value
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////////////
	// Cycles since the last marker; saturates so an idle link never wraps into a false gap
	logic [15:0] gap_r;
	always_ff @(posedge sys_clk) begin
		if (!reset_n) gap_r <= 16'hffff;
		else if (marker_msg_valid) gap_r <= 16'h1;
		else if (gap_r != 16'hffff) gap_r <= gap_r + 16'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field outputs must agree with what software reads back
	chk_tx_sel_read:
	assert property (reg_rd && reg_addr == `LMAC_OFS_HAM |=> reg_rdata[14:12] == tx_marker_select)
		else $error("transmit marker select differs from read-back");
	chk_rx_sel_read:
	assert property (reg_rd && reg_addr == `LMAC_OFS_RMD |=> reg_rdata[14:12] == rx_marker_select)
		else $error("receive marker select differs from read-back");
	chk_fifo_sync_read:
	assert property (reg_rd && reg_addr == `LMAC_OFS_FSC |=> {reg_rdata[15:11], reg_rdata[9:0]}
		== {tx_fifo_depth_select, tx_fifo_watermark_select, sync_code_value})
		else $error("fifo or sync code field differs from read-back");
	// Marker traffic
	chk_marker_crc:
	assert property (marker_msg_valid |-> marker_msg.crc == 32'hfe0000fe)
		else $error("marker check word wrong");
	chk_marker_gap:
	assert property (marker_msg_valid |-> gap_r >= 16'(PERIOD))
		else $error("markers closer than the repeat interval");
	chk_marker_lane:
	assert property (tx_marker_lane != '0 && $stable(tx_marker_select)
		|-> tx_marker_lane == (LANES'(1) << tx_marker_select[1:0]))
		else $error("marker lane does not follow the select field");
	// Detection turns off two edges after the enable is written low
	chk_detect_off:
	assert property (reg_wr && reg_addr == `LMAC_OFS_RMD && !reg_wdata[11] |=> ##1 !rx_marker_detect_en)
		else $error("marker detection stayed on");
	chk_sync_onehot:
	assert property (sync_code_override_enable != '0 |-> $onehot(sync_code_override_enable))
		else $error("sync code override on more than one lane");

	cover property (marker_msg_valid);
	cover property (rx_marker_detect_en);
	cover property (sync_code_override_enable != '0);
endmodule // lmac_top_props

bind lmac_top lmac_top_props #(.LANES(LANES), .PERIOD(PERIOD)) u_props (
	.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.tx_marker_select(tx_marker_select), .tx_marker_lane(tx_marker_lane),
	.marker_msg(marker_msg), .marker_msg_valid(marker_msg_valid),
	.rx_marker_select(rx_marker_select), .rx_marker_detect_en(rx_marker_detect_en),
	.tx_fifo_depth_select(tx_fifo_depth_select),
	.tx_fifo_watermark_select(tx_fifo_watermark_select),
	.sync_code_override_enable(sync_code_override_enable), .sync_code_value(sync_code_value)
);
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the lane marker configuration bank.
// Assumes the checker is bound from its own file; marker interval shortened to 4.
`timescale 1ns/1ps
`default_nettype none
`include "lmac_cfg.svh"

`define CHK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("Error at %0t: got %0h, expected %0h", $time, (got), (exp)); \
	end \
end

module tb import lmac_pkg::*; ;
	localparam int PER = 4;
	logic             sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic [7:0]       reg_addr = 8'h0;
	logic [15:0]      reg_wdata = 16'h0, reg_rdata, e_rd, d;
	logic [39:0]      src [4] = '{default: 40'h0};
	logic [39:0]      rx_out;
	logic [2:0]       tx_marker_select, rx_marker_select, tx_fifo_depth_select;
	logic [3:0]       tx_marker_lane, sync_code_override_enable, m;
	logic [1:0]       tx_fifo_watermark_select;
	logic [9:0]       sync_code_value;
	logic             marker_msg_valid, rx_marker_detect_en;
	lmac_marker_msg_t marker_msg;
	lmac_lane_cfg_t [3:0] lane_cfg;
	logic [15:0]      model [4];
	logic [15:0]      exp_q [$];
	integer           seed = 55193;
	int               err_total = 0, checks_done = 0, n, i, k;

	lmac_top #(.LANES(4), .SYM_W(10), .PERIOD(PER)) dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ls_same_in(src[0]), .ls_alt_in(src[1]), .hs_same_in(src[2]), .hs_alt_in(src[3]),
		.rx_out(rx_out), .tx_marker_select(tx_marker_select), .tx_marker_lane(tx_marker_lane),
		.marker_msg(marker_msg), .marker_msg_valid(marker_msg_valid),
		.rx_marker_select(rx_marker_select), .rx_marker_detect_en(rx_marker_detect_en),
		.tx_fifo_depth_select(tx_fifo_depth_select),
		.tx_fifo_watermark_select(tx_fifo_watermark_select),
		.sync_code_override_enable(sync_code_override_enable),
		.sync_code_value(sync_code_value), .lane_cfg(lane_cfg));

	initial forever #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks; each leaves a quiet cycle so a strobe is never set twice in one step
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Counts falling edges up to the next marker, bounded so a dead generator cannot hang
	task automatic wait_valid;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (marker_msg_valid !== 1'b1 && n < 100);
		`CHK(marker_msg_valid, 1'b1)
		`CHK(marker_msg.crc, 32'hfe0000fe)
	endtask
	task automatic results;
		$display("Checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Read data stands only in the cycle after the strobe, so it is sampled there
	always @(posedge sys_clk) rd_d <= reg_rd;
	always @(negedge sys_clk) begin
		if (rd_d) begin
			e_rd = exp_q.pop_front();
			`CHK(reg_rdata, e_rd)
		end
	end

	initial begin
		#200000;
		err_total++;
		results;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (k = 0; k < 4; k++) src[k] <= 40'({$random(seed), $random(seed)});
		@(negedge sys_clk);
		for (k = 0; k < 4; k++) begin
			model[k] = 16'h3020 | 16'(k * 257);
			`CHK(lane_cfg[k], model[k])
		end
		`CHK({tx_marker_select, rx_marker_select, tx_fifo_depth_select}, 9'h0)
		`CHK({tx_fifo_watermark_select, sync_code_override_enable}, 6'h0)
		`CHK(sync_code_value, 10'h2bc)
		@(posedge sys_clk);
		rd(8'h17, 16'h02bc);
		rd(8'h18, 16'h0cc8);
		rd(8'h19, 16'h02bc);
		rd(8'h1b, 16'h3020);
		rd(8'h40, 16'h0000);
		for (k = 1; k < 4; k++) begin
			wr(8'h30, 16'(k * 64 + 15));
			rd(8'h1b, model[k]);
		end
		$display("Test reset values done");
		// Generation enable with select 5; reserved bits rewritten with their reset value
		wr(8'h17, 16'h5abc);
		wait_valid;
		wait_valid;
		`CHK(n, PER)
		`CHK({marker_msg.lane, tx_marker_select, tx_marker_lane}, 10'h2d2)
		@(posedge sys_clk);
		wr(8'h17, 16'h02bc);
		repeat (3) @(negedge sys_clk);
		`CHK(tx_marker_lane, 4'h0)
		@(posedge sys_clk);
		wr(8'h31, 16'h0006);
		wait_valid;
		@(posedge sys_clk);
		wr(8'h31, 16'h0002);
		repeat (3) @(posedge sys_clk);
		n = 0;
		repeat (2 * PER) begin
			@(negedge sys_clk);
			n += marker_msg_valid;
		end
		`CHK(n, 0)
		@(posedge sys_clk);
		$display("Test marker generation done");
		// Detection only while bitwise interleaving is on
		wr(8'h31, 16'h0001);
		repeat (2) @(negedge sys_clk);
		`CHK(rx_marker_detect_en, 1'b1)
		@(posedge sys_clk);
		rd(8'h31, 16'h0001);
		rd(8'h32, 16'h0202);
		wr(8'h18, 16'h44c8);
		repeat (2) @(negedge sys_clk);
		`CHK({rx_marker_select, rx_marker_detect_en}, 4'h8)
		@(posedge sys_clk);
		wr(8'h31, 16'h0000);
		wr(8'h18, 16'h0cc8);
		repeat (2) @(negedge sys_clk);
		`CHK(rx_marker_detect_en, 1'b0)
		@(posedge sys_clk);
		$display("Test marker detection done");
		// Fifo selects and sync code, steered first to lane 2 then lane 1
		wr(8'h30, 16'h002f);
		wr(8'h19, 16'hdd55);
		repeat (2) @(negedge sys_clk);
		`CHK({tx_fifo_depth_select, tx_fifo_watermark_select}, 5'h1b)
		`CHK({sync_code_override_enable, sync_code_value}, 14'h1155)
		@(posedge sys_clk);
		wr(8'h30, 16'h001f);
		repeat (2) @(negedge sys_clk);
		`CHK(sync_code_override_enable, 4'h2)
		@(posedge sys_clk);
		rd(8'h19, 16'hdd55);
		$display("Test fifo and sync code done");
		// Masked lane writes cycling through every receive source code
		for (k = 0; k < 8; k++) begin
			src[k % 4] <= 40'({$random(seed), $random(seed)});
			m = 4'($random(seed));
			d = 16'($random(seed));
			d[12:11] = 2'(k);
			wr(8'h30, {8'h0, 2'(k), 2'b0, m});
			wr(8'h1b, d);
			for (i = 0; i < 4; i++) if (m[i]) model[i] = d;
			repeat (2) @(negedge sys_clk);
			for (i = 0; i < 4; i++) begin
				`CHK(lane_cfg[i], model[i])
				`CHK(rx_out[i*10 +: 10], src[model[i][12:11]][model[i][9:8]*10 +: 10])
			end
			@(posedge sys_clk);
			rd(8'h1b, model[k % 4]);
		end
		$display("Test lane source select done");
		results;
	end
endmodule // tb
`default_nettype wire
